// ===== pmtb_pkg.sv
package pmtb_pkg;

    // ************************************************************
    // register map (word index times four gives the byte address)
    // ************************************************************
    localparam logic [3:0] ADDR_TIME_BASE_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_INPUT_CLOCK_PRESCALE = 4'h4;
    localparam logic [3:0] ADDR_PRIMARY_PERIOD = 4'h8;
    localparam logic [3:0] ADDR_SPECIAL_EVENT_COMPARE = 4'hC;

    // ************************************************************
    // time base control fields
    // ************************************************************
    localparam int BIT_MODULE_ENABLE = 15;
    localparam int BIT_IDLE_STOP = 13;
    localparam int BIT_SE_PENDING = 12;
    localparam int BIT_SE_IRQ_ENABLE = 11;
    localparam int BIT_IMMEDIATE_UPDATE = 10;
    localparam int BIT_SYNC_POLARITY = 9;
    localparam int BIT_SYNC_OUT_ENABLE = 8;
    localparam int BIT_EXT_SYNC_ENABLE = 7;
    localparam int POS_SYNC_SOURCE = 4;
    localparam int POS_POSTSCALE = 0;
    // writable bits of the control register; bit 14 and pending bit excluded
    localparam logic [15:0] CONTROL_WRITE_MASK = 16'hAFFF;

    // ************************************************************
    // sync source and prescale codes and reset values
    // ************************************************************
    localparam logic [2:0] SYNC_SRC_PIN = 3'h0;
    localparam logic [2:0] SYNC_SRC_TRIG16 = 3'h2;
    localparam logic [2:0] SYNC_SRC_TRIG17 = 3'h3;
    localparam logic [2:0] PRESCALE_RESERVED = 3'h7;

    localparam logic [15:0] RESET_CONTROL = 16'h0000;
    localparam logic [2:0] RESET_PRESCALE = 3'h0;
    localparam logic [15:0] RESET_PERIOD = 16'hFFF8;
    localparam logic [15:0] RESET_COMPARE = 16'h0000;

endpackage

// ===== pmtb_time_base.sv
`timescale 1ns/1ns

module pmtb_time_base #(
    parameter int DATA_WIDTH = 16,
    parameter int PRESCALE_WIDTH = 6
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // system state
    input wire logic cpuIdle,
    // sync sources
    input wire logic syncInputPin,
    input wire logic trigGenOutput16,
    input wire logic trigGenOutput17,
    // sync output pin
    output logic syncOutputPin,
    output logic syncOutputPinOe,
    // event outputs
    output logic adcTrigger,
    output logic specialEventIrq,
    output logic [DATA_WIDTH-1:0] primaryMasterTimer
);

    // ************************************************************
    // registers
    // ************************************************************
    logic [15:0] control_q;
    logic [2:0] prescaleSel_q;
    logic [DATA_WIDTH-1:0] periodBuffer_q;
    logic [DATA_WIDTH-1:0] periodActive_q;
    logic [DATA_WIDTH-1:0] compare_q;
    logic [DATA_WIDTH-1:0] count_q;
    logic [PRESCALE_WIDTH-1:0] prescaleCnt_q;
    logic [3:0] postCnt_q;
    logic syncIn_q;
    logic pending_q;

    logic enable;
    logic accessReq;
    logic mapped;
    logic wrCtl, wrPre, wrPer, wrCmp;
    logic tick;
    logic wrap;
    logic match;
    logic seEvent;
    logic syncSel;
    logic syncActive;
    logic syncEdge;
    logic [PRESCALE_WIDTH-1:0] prescaleLimit;
    logic [15:0] controlRead;

    assign enable = control_q[pmtb_pkg::BIT_MODULE_ENABLE];

    // ************************************************************
    // wishbone decode
    // ************************************************************
    // ack comes one cycle after the request and falls the next cycle
    assign accessReq = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign mapped = (wb_adr_i == pmtb_pkg::ADDR_TIME_BASE_CONTROL) ||
                    (wb_adr_i == pmtb_pkg::ADDR_INPUT_CLOCK_PRESCALE) ||
                    (wb_adr_i == pmtb_pkg::ADDR_PRIMARY_PERIOD) ||
                    (wb_adr_i == pmtb_pkg::ADDR_SPECIAL_EVENT_COMPARE);
    // registers are at most 16 bits wide, so only the low two lanes matter
    assign wrCtl = accessReq && wb_we_i && (wb_adr_i == pmtb_pkg::ADDR_TIME_BASE_CONTROL);
    assign wrPre = accessReq && wb_we_i && (wb_adr_i == pmtb_pkg::ADDR_INPUT_CLOCK_PRESCALE);
    assign wrPer = accessReq && wb_we_i && (wb_adr_i == pmtb_pkg::ADDR_PRIMARY_PERIOD);
    assign wrCmp = accessReq && wb_we_i && (wb_adr_i == pmtb_pkg::ADDR_SPECIAL_EVENT_COMPARE);

    function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [31:0] dat,
                                              input logic [3:0] sel);
        logic [15:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            res[15:8] = dat[15:8];
        end
        return res;
    endfunction

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= accessReq && mapped;
            wb_err_o <= accessReq && !mapped;
        end
    end

    assign controlRead = (control_q & pmtb_pkg::CONTROL_WRITE_MASK) |
                         ({15'h0000, pending_q} << pmtb_pkg::BIT_SE_PENDING);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_dat_o <= 32'h00000000;
        end else if (accessReq && !wb_we_i) begin
            unique case (wb_adr_i)
                pmtb_pkg::ADDR_TIME_BASE_CONTROL: wb_dat_o <= {16'h0000, controlRead};
                pmtb_pkg::ADDR_INPUT_CLOCK_PRESCALE: wb_dat_o <= {29'h00000000, prescaleSel_q};
                pmtb_pkg::ADDR_PRIMARY_PERIOD: wb_dat_o <= {16'h0000, periodBuffer_q};
                pmtb_pkg::ADDR_SPECIAL_EVENT_COMPARE: wb_dat_o <= {16'h0000, compare_q};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end else begin
            wb_dat_o <= 32'h00000000;
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            control_q <= pmtb_pkg::RESET_CONTROL;
        end else if (wrCtl) begin
            control_q <= laneMerge(control_q, wb_dat_i, wb_sel_i) & pmtb_pkg::CONTROL_WRITE_MASK;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prescaleSel_q <= pmtb_pkg::RESET_PRESCALE;
        end else if (wrPre && wb_sel_i[0]) begin
            prescaleSel_q <= wb_dat_i[2:0];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            periodBuffer_q <= pmtb_pkg::RESET_PERIOD;
        end else if (wrPer) begin
            periodBuffer_q <= laneMerge(periodBuffer_q, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            compare_q <= pmtb_pkg::RESET_COMPARE;
        end else if (wrCmp) begin
            compare_q <= laneMerge(compare_q, wb_dat_i, wb_sel_i);
        end
    end

    // ************************************************************
    // prescaler
    // ************************************************************
    // reserved code 111 behaves as divide-by-64
    assign prescaleLimit = (prescaleSel_q == pmtb_pkg::PRESCALE_RESERVED) ?
        {PRESCALE_WIDTH{1'b1}} :
        PRESCALE_WIDTH'((7'h01 << prescaleSel_q) - 7'h01);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prescaleCnt_q <= '0;
        end else if (!enable) begin
            prescaleCnt_q <= '0;
        end else if (!(cpuIdle && control_q[pmtb_pkg::BIT_IDLE_STOP])) begin
            prescaleCnt_q <= (prescaleCnt_q >= prescaleLimit) ? '0 : prescaleCnt_q + 1'b1;
        end
    end

    assign tick = enable && !(cpuIdle && control_q[pmtb_pkg::BIT_IDLE_STOP]) &&
                  (prescaleCnt_q >= prescaleLimit);

    // ************************************************************
    // external sync
    // ************************************************************
    always_comb begin
        unique case (control_q[pmtb_pkg::POS_SYNC_SOURCE +: 3])
            pmtb_pkg::SYNC_SRC_PIN: syncSel = syncInputPin;
            pmtb_pkg::SYNC_SRC_TRIG16: syncSel = trigGenOutput16;
            pmtb_pkg::SYNC_SRC_TRIG17: syncSel = trigGenOutput17;
            default: syncSel = 1'b0;
        endcase
    end

    // polarity applied before edge detection so either sense gives one pulse
    assign syncActive = syncSel ^ control_q[pmtb_pkg::BIT_SYNC_POLARITY];

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            syncIn_q <= 1'b0;
        end else begin
            syncIn_q <= syncActive;
        end
    end

    assign syncEdge = control_q[pmtb_pkg::BIT_EXT_SYNC_ENABLE] && syncActive && !syncIn_q;

    // ************************************************************
    // primary master timer
    // ************************************************************
    assign wrap = tick && (count_q >= periodActive_q);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
        end else if (!enable) begin
            count_q <= '0;
        end else if (syncEdge || wrap) begin
            count_q <= '0;
        end else if (tick) begin
            count_q <= count_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            periodActive_q <= pmtb_pkg::RESET_PERIOD;
        end else if (control_q[pmtb_pkg::BIT_IMMEDIATE_UPDATE] || !enable) begin
            periodActive_q <= periodBuffer_q;
        end else if (wrap || syncEdge) begin
            periodActive_q <= periodBuffer_q;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            primaryMasterTimer <= '0;
        end else begin
            primaryMasterTimer <= count_q;
        end
    end

    // ************************************************************
    // special event compare and postscaler
    // ************************************************************
    // one match per count value: qualified by the tick that leaves it
    assign match = enable && tick && (count_q == compare_q);
    assign seEvent = match && (postCnt_q >= control_q[pmtb_pkg::POS_POSTSCALE +: 4]);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            postCnt_q <= 4'h0;
        end else if (!enable) begin
            postCnt_q <= 4'h0;
        end else if (match) begin
            postCnt_q <= seEvent ? 4'h0 : postCnt_q + 4'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            adcTrigger <= 1'b0;
        end else begin
            adcTrigger <= seEvent;
        end
    end

    // pending follows the interrupt enable: clearing that enable clears it, a new event wins
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pending_q <= 1'b0;
        end else if (seEvent && control_q[pmtb_pkg::BIT_SE_IRQ_ENABLE]) begin
            pending_q <= 1'b1;
        end else if (!control_q[pmtb_pkg::BIT_SE_IRQ_ENABLE]) begin
            pending_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            specialEventIrq <= 1'b0;
        end else begin
            specialEventIrq <= seEvent && control_q[pmtb_pkg::BIT_SE_IRQ_ENABLE];
        end
    end

    // ************************************************************
    // sync output
    // ************************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            syncOutputPin <= 1'b0;
            syncOutputPinOe <= 1'b0;
        end else begin
            syncOutputPinOe <= control_q[pmtb_pkg::BIT_SYNC_OUT_ENABLE];
            syncOutputPin <= (enable && control_q[pmtb_pkg::BIT_SYNC_OUT_ENABLE] && wrap) ^
                             control_q[pmtb_pkg::BIT_SYNC_POLARITY];
        end
    end

endmodule

// ===== pmtb_props.sv
`timescale 1ns/1ns
// ************************************************************
// time base checker
// ************************************************************
module pmtb_props (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // pins and events
    input wire logic cpuIdle,
    input wire logic syncOutputPin,
    input wire logic syncOutputPinOe,
    input wire logic adcTrigger,
    input wire logic specialEventIrq,
    input wire logic [15:0] primaryMasterTimer
);
    // shadow taken at the ack edge; it lags the design by a cycle, so the checks that read ctlQ skip ack cycles
    logic [15:0] ctlQ;
    logic [15:0] cmpQ;
    logic enQ;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctlQ <= 16'h0000;
            cmpQ <= 16'h0000;
            enQ <= 1'b0;
        end else begin
            enQ <= ctlQ[15];
            if (wb_ack_o && wb_we_i && wb_adr_i == 4'h0) ctlQ <= wb_dat_i[15:0];
            if (wb_ack_o && wb_we_i && wb_adr_i == 4'hC) cmpQ <= wb_dat_i[15:0];
        end
    end
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    property p_bus; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> (wb_ack_o ^ wb_err_o) ##1 (!wb_ack_o); endproperty
    a_bus: assert property (p_bus) else $error("bus answer missing or held");
    property p_oe; !wb_ack_o |-> syncOutputPinOe == ctlQ[8]; endproperty
    a_oe: assert property (p_oe) else $error("sync output enable wrong");
    property p_off; !ctlQ[15] && !enQ && !wb_ack_o && !$past(wb_ack_o) |-> primaryMasterTimer == 16'h0000
        && !adcTrigger && !specialEventIrq && syncOutputPin == ctlQ[9]; endproperty
    a_off: assert property (p_off) else $error("activity while disabled");
    property p_step; $changed(primaryMasterTimer) |-> primaryMasterTimer == 16'h0000
        || primaryMasterTimer == $past(primaryMasterTimer) + 16'h0001; endproperty
    a_step: assert property (p_step) else $error("counter jumped");
    // the timer copy lags the counter by one cycle, just as the trigger does
    property p_cmp; adcTrigger |-> primaryMasterTimer == cmpQ; endproperty
    a_cmp: assert property (p_cmp) else $error("trigger without compare match");
    property p_irq; adcTrigger && !wb_ack_o && !$past(wb_ack_o) |-> specialEventIrq == ctlQ[11]; endproperty
    a_irq: assert property (p_irq) else $error("interrupt request wrong");
    property p_irqsrc; specialEventIrq |-> adcTrigger; endproperty
    a_irqsrc: assert property (p_irqsrc) else $error("interrupt without trigger");
    property p_sync; syncOutputPin != ctlQ[9] && !wb_ack_o && !$past(wb_ack_o)
        |=> (primaryMasterTimer == 16'h0000 && syncOutputPin == ctlQ[9]); endproperty
    a_sync: assert property (p_sync) else $error("sync output pulse wrong");
    property p_idle; cpuIdle && $past(cpuIdle) && $past(cpuIdle, 2) && ctlQ[13] && !wb_ack_o
        |-> $stable(primaryMasterTimer); endproperty
    a_idle: assert property (p_idle) else $error("counter ran in idle");
endmodule

bind pmtb_time_base pmtb_props u_props (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .cpuIdle(cpuIdle), .syncOutputPin(syncOutputPin), .syncOutputPinOe(syncOutputPinOe),
    .adcTrigger(adcTrigger), .specialEventIrq(specialEventIrq), .primaryMasterTimer(primaryMasterTimer));

// ===== pmtb_sync_partner.sv
`timescale 1ns/1ns
// ************************************************************
// external sync source
// ************************************************************
module pmtb_sync_partner (
    // clock
    input wire logic ref_clk,
    // requests from the bench
    input wire logic syncPolarity,
    input wire logic syncRequest,
    // pin toward the block
    output logic syncInputPin
);
    // launched from a flop so the edge never lands on the sampling edge
    always_ff @(posedge ref_clk) begin
        syncInputPin <= syncRequest ^ syncPolarity;
    end
endmodule

// ===== pmtb_time_base_bench.sv
`timescale 1ns/1ns
module pmtb_time_base_bench;
    // ************************************************************
    // stimulus and observed pins
    // ************************************************************
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, cpuIdle = 1'b0, syncReq = 1'b0, t16 = 1'b0, t17 = 1'b0, pol = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic ack, err, errSeen, syncIn, syncOut, syncOe, adcTrig, seIrq;
    logic [15:0] pmt, q, per, ctl;
    logic [3:0] ps;
    logic [2:0] sSrc [6] = '{3'h0, 3'h2, 3'h3, 3'h2, 3'h1, 3'h0};
    logic [2:0] sFire [6] = '{3'h1, 3'h2, 3'h4, 3'h1, 3'h7, 3'h1};
    logic [5:0] sEn = 6'h1F;
    logic [5:0] sExp = 6'h07;
    int n_errors = 0, checked = 0, seed = 60, tick = 0, t0, k;
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) tick <= tick + 1;
    pmtb_time_base dut (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .cpuIdle(cpuIdle), .syncInputPin(syncIn), .trigGenOutput16(t16), .trigGenOutput17(t17),
        .syncOutputPin(syncOut), .syncOutputPinOe(syncOe), .adcTrigger(adcTrig), .specialEventIrq(seIrq),
        .primaryMasterTimer(pmt));
    pmtb_sync_partner partner (.ref_clk(ref_clk), .syncPolarity(pol), .syncRequest(syncReq), .syncInputPin(syncIn));
    // ************************************************************
    // tasks
    // ************************************************************
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    // called just after a rising edge; holds the request until ack or err is sampled
    task automatic bus(input logic [3:0] a, input logic w, input logic [15:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_errors++;
            tally_and_finish;
        end
        q = rdat[15:0];
        errSeen = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
        bus(a, 1'b0, 16'h0000);
        chk(nm, e, q);
    endtask
    task automatic waitEv(input logic adcSel);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while ((adcSel ? adcTrig : syncOut ^ pol) !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            n_errors++;
            tally_and_finish;
        end
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        rd(4'h0, 16'h0000, "control");
        rd(4'h4, 16'h0000, "prescale");
        rd(4'h8, 16'hFFF8, "period");
        rd(4'hC, 16'h0000, "compare");
        bus(4'h2, 1'b0, 16'h0000);
        chk("unmapped", 1'b1, errSeen);
        wr(4'h0, 16'h5FFF);
        rd(4'h0, 16'h0FFF, "control unused");
        wr(4'h4, 16'hFFFF);
        rd(4'h4, 16'h0007, "prescale unused");
        $display("test registers done");
        // code 7 is reserved and runs as divide-by-64
        for (k = 0; k < 8; k++) begin
            per = 16'(2 + ($random(seed) & 3));
            ps = 4'($random(seed));
            ctl = 16'h8100 | 16'($random(seed) & 32'h00000A00) | 16'(ps);
            pol <= ctl[9];
            wr(4'h0, 16'h0000);
            wr(4'h4, 16'(k));
            wr(4'h8, per);
            wr(4'hC, 16'h0001);
            wr(4'h0, ctl & 16'h7FFF);
            wr(4'h0, ctl);
            waitEv(1'b0);
            t0 = tick;
            waitEv(1'b0);
            chk("sync interval", (32'(per) + 1) << (k > 6 ? 6 : k), tick - t0);
            chk("sync oe", 1'b1, syncOe);
            waitEv(1'b1);
            t0 = tick;
            waitEv(1'b1);
            chk("adc interval", (32'(ps) + 1) * (32'(per) + 1) << (k > 6 ? 6 : k), tick - t0);
            chk("irq", ctl[11], seIrq);
            rd(4'h0, ctl | {3'b000, ctl[11], 12'h000}, "pending");
            wr(4'h0, 16'h0000);
            rd(4'h0, 16'h0000, "pending clear");
            chk("timer off", 16'h0000, pmt);
            chk("oe off", 1'b0, syncOe);
        end
        $display("test prescale done");
        pol <= 1'b0;
        for (k = 0; k < 2; k++) begin
            wr(4'h4, 16'h0000);
            wr(4'h8, 16'h0005);
            wr(4'h0, 16'(k << 10));
            wr(4'h0, 16'h8100 | 16'(k << 10));
            waitEv(1'b0);
            t0 = tick;
            wr(4'h8, 16'h0009);
            waitEv(1'b0);
            chk("period update", k ? 32'h0000000A : 32'h00000006, tick - t0);
            wr(4'h0, 16'h0000);
        end
        $display("test period update done");
        for (k = 0; k < 6; k++) begin
            pol <= (k == 0);
            ctl = 16'(k == 0) << 9 | 16'(sEn[k]) << 7 | 16'(sSrc[k]) << 4;
            wr(4'h8, 16'h00FF);
            wr(4'h0, ctl);
            wr(4'h0, ctl | 16'h8000);
            repeat (30) @(posedge ref_clk);
            syncReq <= sFire[k][0];
            t16 <= sFire[k][1];
            t17 <= sFire[k][2];
            repeat (2) @(posedge ref_clk);
            syncReq <= 1'b0;
            t16 <= 1'b0;
            t17 <= 1'b0;
            repeat (6) @(posedge ref_clk);
            chk("sync reset", sExp[k], pmt < 16'h0010);
            wr(4'h0, 16'h0000);
        end
        $display("test external sync done");
        pol <= 1'b0;
        for (k = 0; k < 2; k++) begin
            wr(4'h0, 16'h8000 | 16'(k << 13));
            cpuIdle <= 1'b1;
            repeat (4) @(posedge ref_clk);
            q = pmt;
            repeat (8) @(posedge ref_clk);
            chk("idle stop", k, pmt == q);
            cpuIdle <= 1'b0;
            wr(4'h0, 16'h0000);
        end
        $display("test idle done");
        tally_and_finish;
    end
endmodule
